// ### verilog/bsx_exec_unit.sv
// bit manipulation, shift and status flag execution unit of the core
//
// Behaviour
// - stack pop loads destination from stack data, flags unchanged.
// - io bit set forces bit b of io register to one, rest untouched.
// - io bit clear forces bit b of io register to zero, rest untouched.
// - left shift moves bits up, zero into bit 0, updates Z C N V.
// - logical right shift moves bits down, zero into bit 7.
// - rotate left: carry into bit 0, old bit 7 becomes carry.
// - rotate right: carry into bit 7, old bit 0 becomes carry.
// - arithmetic right shift moves bits down and keeps the sign bit.
// - nibble swap exchanges halves of destination, no flag changes.
// - status bit set or clear acts on flag chosen by bit field.
// - bit store copies source bit b into transfer flag only.
// - bit load copies transfer flag into destination bit b, flags unchanged.
// - carry set and carry clear drive only the carry flag.
// - negative set and clear drive only the negative flag.
// - zero set and clear drive only the zero flag.
// - interrupt enable sets, interrupt disable clears global interrupt flag.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bsx_exec_unit (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // decoder side
  input wire logic i_op_valid,
  input wire bsx_pkg::bsx_op_t i_op_code,
  input wire logic [7:0] i_dst_data,
  input wire logic [7:0] i_src_data,
  input wire logic [2:0] i_bit_sel,
  input wire logic [5:0] i_io_addr,
  output logic o_op_ready,
  // register file write-back
  output logic o_rd_we,
  output logic [7:0] o_rd_wdata,
  // stack read
  output logic o_stack_rd,
  input wire logic [7:0] i_stack_data,
  // io space
  output logic o_io_rd,
  output logic [5:0] o_io_rd_addr,
  input wire logic [7:0] i_io_rdata,
  output logic o_io_we,
  output logic [5:0] o_io_wr_addr,
  output logic [7:0] o_io_wdata,
  // flags to the rest of the core
  output logic [7:0] o_status_flags,
  output logic o_irq_enable,
  // software register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata
);

  // every piece of state lives in this one word; d is the next value, q the registered one
  typedef struct packed {
    bsx_pkg::bsx_fsm_t st;
    logic [7:0] flags;
    logic [7:0] ctrl;
    logic [7:0] result;
    logic [7:0] op_cnt;
    logic rd_we;
    logic [7:0] rd_wdata;
    logic io_we;
    logic [7:0] io_wdata;
    logic [5:0] io_addr;
    logic [2:0] bit_sel;
    logic io_set;
    logic [7:0] rdata;
  } bsx_state_t;

  bsx_state_t q;
  bsx_state_t d;

  logic take;
  logic [7:0] sh_result;
  logic sh_carry;
  logic sh_neg;
  logic sh_zero;
  logic sh_ovf;
  logic [7:0] bld_result;
  logic [7:0] io_result;

  function automatic logic [7:0] read_mux(input logic [3:0] addr, input bsx_state_t s);
    logic [7:0] v;
    v = bsx_pkg::RDATA_UNMAPPED;
    case (addr)
      bsx_pkg::REG_STATUS: v = s.flags;
      bsx_pkg::REG_CTRL: v = s.ctrl;
      bsx_pkg::REG_RESULT: v = s.result;
      bsx_pkg::REG_OPCOUNT: v = s.op_cnt;
      default: v = bsx_pkg::RDATA_UNMAPPED;
    endcase
    return v;
  endfunction

  function automatic logic is_io_op(input bsx_pkg::bsx_op_t op);
    logic r;
    r = (op == bsx_pkg::BSX_IO_BIT_SET_OP) | (op == bsx_pkg::BSX_IO_BIT_CLEAR_OP);
    return r;
  endfunction

  // one-hot mask of the status bit named by the op's bit field
  function automatic logic [7:0] flag_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h00;
    m[sel] = 1'b1;
    return m;
  endfunction

  // shifts own Z, C, N and V; S, H, T and I pass through untouched
  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic z,
                                             input logic c, input logic n, input logic v);
    logic [7:0] r;
    r = f;
    r[bsx_pkg::FLAG_Z] = z;
    r[bsx_pkg::FLAG_C] = c;
    r[bsx_pkg::FLAG_N] = n;
    r[bsx_pkg::FLAG_V] = v;
    return r;
  endfunction

  // an op is only taken while idle and enabled by software
  assign o_op_ready = (q.st == bsx_pkg::BSX_ST_IDLE) & q.ctrl[bsx_pkg::CTRL_EN_BIT];
  assign take = i_op_valid & o_op_ready;

  // first cycle of the two-cycle ops: strobes are combinational on the take
  assign o_stack_rd = take & (i_op_code == bsx_pkg::BSX_STACK_POP_OP);
  assign o_io_rd = take & is_io_op(i_op_code);
  // the address rides with the read strobe, so it cannot wait for a flop
  assign o_io_rd_addr = i_io_addr;

  bsx_shifter u_shifter (
    .i_op(i_op_code),
    .i_data(i_dst_data),
    .i_carry(q.flags[bsx_pkg::FLAG_C]),
    .o_result(sh_result),
    .o_carry(sh_carry),
    .o_neg(sh_neg),
    .o_zero(sh_zero),
    .o_ovf(sh_ovf)
  );

  bsx_bit_unit #(
    .WIDTH(8),
    .SEL_W(3)
  ) u_bld (
    .i_data(i_dst_data),
    .i_sel(i_bit_sel),
    .i_val(q.flags[bsx_pkg::FLAG_T]),
    .o_data(bld_result)
  );

  bsx_bit_unit #(
    .WIDTH(8),
    .SEL_W(3)
  ) u_io_bit (
    .i_data(i_io_rdata),
    .i_sel(q.bit_sel),
    .i_val(q.io_set),
    .o_data(io_result)
  );

  always_comb
  begin
    d = q;
    d.rd_we = 1'b0;
    d.io_we = 1'b0;
    d.rdata = bsx_pkg::RDATA_UNMAPPED;

    // software writes land first so a flag op in the same cycle overrides its bit
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        bsx_pkg::REG_STATUS: d.flags = i_reg_wdata;
        bsx_pkg::REG_CTRL: d.ctrl = i_reg_wdata;
        default: d.ctrl = q.ctrl;
      endcase
    end
    if (i_reg_rd)
    begin
      d.rdata = read_mux(i_reg_addr, q);
    end

    case (q.st)
      bsx_pkg::BSX_ST_IDLE:
      begin
        if (take)
        begin
          d.op_cnt = q.op_cnt + 8'h01;
          case (i_op_code)
            bsx_pkg::BSX_STACK_POP_OP:
            begin
              d.st = bsx_pkg::BSX_ST_POP;
            end
            bsx_pkg::BSX_IO_BIT_SET_OP,
            bsx_pkg::BSX_IO_BIT_CLEAR_OP:
            begin
              d.st = bsx_pkg::BSX_ST_IO;
              d.io_addr = i_io_addr;
              d.bit_sel = i_bit_sel;
              d.io_set = (i_op_code == bsx_pkg::BSX_IO_BIT_SET_OP);
            end
            bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP,
            bsx_pkg::BSX_SHIFT_RIGHT_LOGICAL_OP,
            bsx_pkg::BSX_ROTATE_LEFT_CARRY_OP,
            bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP,
            bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP:
            begin
              d.rd_we = 1'b1;
              d.rd_wdata = sh_result;
              d.result = sh_result;
              d.flags = shift_flags(d.flags, sh_zero, sh_carry, sh_neg, sh_ovf);
            end
            bsx_pkg::BSX_NIBBLE_SWAP_OP:
            begin
              // swap writes back but leaves every flag alone
              d.rd_we = 1'b1;
              d.rd_wdata = {i_dst_data[3:0], i_dst_data[7:4]};
              d.result = {i_dst_data[3:0], i_dst_data[7:4]};
            end
            bsx_pkg::BSX_STATUS_BIT_SET_OP:
            begin
              d.flags = d.flags | flag_mask(i_bit_sel);
            end
            bsx_pkg::BSX_STATUS_BIT_CLEAR_OP:
            begin
              d.flags = d.flags & ~flag_mask(i_bit_sel);
            end
            bsx_pkg::BSX_REG_BIT_TO_TRANSFER_FLAG_OP:
            begin
              d.flags[bsx_pkg::FLAG_T] = i_src_data[i_bit_sel];
            end
            bsx_pkg::BSX_TRANSFER_FLAG_TO_REG_BIT_OP:
            begin
              // transfer flag is only read here, no flag is written
              d.rd_we = 1'b1;
              d.rd_wdata = bld_result;
              d.result = bld_result;
            end
            bsx_pkg::BSX_CARRY_SET_OP:
            begin
              d.flags[bsx_pkg::FLAG_C] = 1'b1;
            end
            bsx_pkg::BSX_CARRY_CLEAR_OP:
            begin
              d.flags[bsx_pkg::FLAG_C] = 1'b0;
            end
            bsx_pkg::BSX_NEGATIVE_SET_OP:
            begin
              d.flags[bsx_pkg::FLAG_N] = 1'b1;
            end
            bsx_pkg::BSX_NEGATIVE_CLEAR_OP:
            begin
              d.flags[bsx_pkg::FLAG_N] = 1'b0;
            end
            bsx_pkg::BSX_ZERO_SET_OP:
            begin
              d.flags[bsx_pkg::FLAG_Z] = 1'b1;
            end
            bsx_pkg::BSX_ZERO_CLEAR_OP:
            begin
              d.flags[bsx_pkg::FLAG_Z] = 1'b0;
            end
            bsx_pkg::BSX_IRQ_ENABLE_OP:
            begin
              d.flags[bsx_pkg::FLAG_I] = 1'b1;
            end
            bsx_pkg::BSX_IRQ_DISABLE_OP:
            begin
              d.flags[bsx_pkg::FLAG_I] = 1'b0;
            end
            default:
            begin
              // unknown codes are consumed and counted in op_cnt, with no other effect
              d.st = bsx_pkg::BSX_ST_IDLE;
            end
          endcase
        end
      end
      bsx_pkg::BSX_ST_POP:
      begin
        // stack data is valid the cycle after the read strobe
        d.rd_we = 1'b1;
        d.rd_wdata = i_stack_data;
        d.result = i_stack_data;
        d.st = bsx_pkg::BSX_ST_IDLE;
      end
      bsx_pkg::BSX_ST_IO:
      begin
        // read-modify-write: unselected bits come back exactly as read
        d.io_we = 1'b1;
        d.io_wdata = io_result;
        d.result = io_result;
        d.st = bsx_pkg::BSX_ST_IDLE;
      end
      default:
      begin
        d.st = bsx_pkg::BSX_ST_IDLE;
      end
    endcase
  end

  // pending strobes are cleared by reset so no stray write leaves the block
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      q.st <= bsx_pkg::BSX_ST_IDLE;
      q.flags <= bsx_pkg::STATUS_RST;
      q.ctrl <= bsx_pkg::CTRL_RST;
      q.result <= bsx_pkg::RESULT_RST;
      q.op_cnt <= bsx_pkg::OPCOUNT_RST;
      q.rd_we <= 1'b0;
      q.rd_wdata <= 8'h00;
      q.io_we <= 1'b0;
      q.io_wdata <= 8'h00;
      q.io_addr <= 6'h00;
      q.bit_sel <= 3'h0;
      q.io_set <= 1'b0;
      q.rdata <= bsx_pkg::RDATA_UNMAPPED;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_rd_we = q.rd_we;
  assign o_rd_wdata = q.rd_wdata;
  assign o_io_we = q.io_we;
  assign o_io_wr_addr = q.io_addr;
  assign o_io_wdata = q.io_wdata;
  assign o_status_flags = q.flags;
  assign o_irq_enable = q.flags[bsx_pkg::FLAG_I];
  assign o_reg_rdata = q.rdata;

endmodule
`default_nettype wire

// ### verilog/bsx_pkg.sv
// shared constants and types of the bit, shift and flag execution unit
package bsx_pkg;

  localparam int DATA_W = 8;
  localparam int BIT_IDX_W = 3;
  localparam int IO_ADDR_W = 6;
  localparam int REG_ADDR_W = 4;

  // bit positions inside status_flags_word
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // software register offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_RESULT = 4'h2;
  localparam logic [3:0] REG_OPCOUNT = 4'h3;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] OPCOUNT_RST = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam logic [2:0] CTRL_EN_BIT = 3'h0;

  typedef enum logic [4:0] {
    BSX_STACK_POP_OP = 5'h00,
    BSX_IO_BIT_SET_OP = 5'h01,
    BSX_IO_BIT_CLEAR_OP = 5'h02,
    BSX_SHIFT_LEFT_LOGICAL_OP = 5'h03,
    BSX_SHIFT_RIGHT_LOGICAL_OP = 5'h04,
    BSX_ROTATE_LEFT_CARRY_OP = 5'h05,
    BSX_ROTATE_RIGHT_CARRY_OP = 5'h06,
    BSX_SHIFT_RIGHT_ARITH_OP = 5'h07,
    BSX_NIBBLE_SWAP_OP = 5'h08,
    BSX_STATUS_BIT_SET_OP = 5'h09,
    BSX_STATUS_BIT_CLEAR_OP = 5'h0A,
    BSX_REG_BIT_TO_TRANSFER_FLAG_OP = 5'h0B,
    BSX_TRANSFER_FLAG_TO_REG_BIT_OP = 5'h0C,
    BSX_CARRY_SET_OP = 5'h0D,
    BSX_CARRY_CLEAR_OP = 5'h0E,
    BSX_NEGATIVE_SET_OP = 5'h0F,
    BSX_NEGATIVE_CLEAR_OP = 5'h10,
    BSX_ZERO_SET_OP = 5'h11,
    BSX_ZERO_CLEAR_OP = 5'h12,
    BSX_IRQ_ENABLE_OP = 5'h13,
    BSX_IRQ_DISABLE_OP = 5'h14
  } bsx_op_t;

  typedef enum logic [1:0] {
    BSX_ST_IDLE = 2'b00,
    BSX_ST_POP = 2'b01,
    BSX_ST_IO = 2'b10
  } bsx_fsm_t;

endpackage

// ### verilog/bsx_bit_unit.sv
// forces one selected bit of a byte to a given value
`timescale 1ns/1ps
`default_nettype none
module bsx_bit_unit #(
  parameter int WIDTH = 8,
  parameter int SEL_W = 3
) (
  input wire logic [WIDTH-1:0] i_data,
  input wire logic [SEL_W-1:0] i_sel,
  input wire logic i_val,
  output logic [WIDTH-1:0] o_data
);

  function automatic logic [WIDTH-1:0] one_hot(input logic [SEL_W-1:0] sel);
    logic [WIDTH-1:0] m;
    m = '0;
    m[sel] = 1'b1;
    return m;
  endfunction

  logic [WIDTH-1:0] sel_mask;

  assign sel_mask = one_hot(i_sel);

  // only the selected lane changes, every other bit passes through
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_lane
      assign o_data[g] = sel_mask[g] ? i_val : i_data[g];
    end
  endgenerate

endmodule
`default_nettype wire

// ### verilog/bsx_shifter.sv
// one-place shifts and rotates through carry with their flag results
`timescale 1ns/1ps
`default_nettype none
module bsx_shifter (
  input wire bsx_pkg::bsx_op_t i_op,
  input wire logic [7:0] i_data,
  input wire logic i_carry,
  output logic [7:0] o_result,
  output logic o_carry,
  output logic o_neg,
  output logic o_zero,
  output logic o_ovf
);

  always_comb
  begin
    o_result = i_data;
    o_carry = i_carry;
    case (i_op)
      bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP:
      begin
        o_result = {i_data[6:0], 1'b0};
        o_carry = i_data[7];
      end
      bsx_pkg::BSX_SHIFT_RIGHT_LOGICAL_OP:
      begin
        o_result = {1'b0, i_data[7:1]};
        o_carry = i_data[0];
      end
      bsx_pkg::BSX_ROTATE_LEFT_CARRY_OP:
      begin
        o_result = {i_data[6:0], i_carry};
        o_carry = i_data[7];
      end
      bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP:
      begin
        o_result = {i_carry, i_data[7:1]};
        o_carry = i_data[0];
      end
      bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP:
      begin
        o_result = {i_data[7], i_data[7:1]};
        o_carry = i_data[0];
      end
      default:
      begin
        o_result = i_data;
        o_carry = i_carry;
      end
    endcase
  end

  assign o_neg = o_result[7];
  assign o_zero = (o_result == 8'h00);
  // overflow after a shift is the new sign bit exclusive-or the new carry
  assign o_ovf = o_result[7] ^ o_carry;

endmodule
`default_nettype wire

// ### sim/bsx_exec_unit_assertions.sv
// timing and result checker for the bit, shift and flag execution unit
`timescale 1ns/1ps
`default_nettype none
module bsx_exec_unit_chk (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_op_valid,
  input wire bsx_pkg::bsx_op_t i_op_code,
  input wire logic [7:0] i_dst_data,
  input wire logic [2:0] i_bit_sel,
  input wire logic [5:0] i_io_addr,
  input wire logic [7:0] i_io_rdata,
  input wire logic [7:0] i_stack_data,
  input wire logic i_reg_wr,
  input wire logic o_op_ready,
  input wire logic o_rd_we,
  input wire logic [7:0] o_rd_wdata,
  input wire logic o_io_we,
  input wire logic [5:0] o_io_wr_addr,
  input wire logic [7:0] o_io_wdata,
  input wire logic [7:0] o_status_flags,
  input wire logic o_irq_enable
);
  logic tk;
  // a software write in the take cycle may legally move the flags, so leave it out
  assign tk = i_op_valid && o_op_ready && !i_reg_wr;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_pop;
    tk && i_op_code == bsx_pkg::BSX_STACK_POP_OP |=> !o_op_ready && !o_rd_we
      ##1 o_rd_we && o_rd_wdata == $past(i_stack_data);
  endproperty
  a_pop: assert property (p_pop) else $error("pop write-back wrong");
  property p_io_set;
    tk && i_op_code == bsx_pkg::BSX_IO_BIT_SET_OP |=> !o_op_ready ##1 o_io_we
      && o_io_wdata == ($past(i_io_rdata) | (8'h01 << $past(i_bit_sel, 2)))
      && o_io_wr_addr == $past(i_io_addr, 2);
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");
  property p_io_clr;
    tk && i_op_code == bsx_pkg::BSX_IO_BIT_CLEAR_OP |=> !o_op_ready ##1 o_io_we
      && o_io_wdata == ($past(i_io_rdata) & ~(8'h01 << $past(i_bit_sel, 2)));
  endproperty
  a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong");
  property p_lsl;
    tk && i_op_code == bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP |=> o_rd_we
      && o_rd_wdata == {$past(i_dst_data[6:0]), 1'b0} && o_status_flags[0] == $past(i_dst_data[7]);
  endproperty
  a_lsl: assert property (p_lsl) else $error("left shift wrong");
  property p_ror;
    tk && i_op_code == bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP |=> o_rd_we
      && o_rd_wdata == {$past(o_status_flags[0]), $past(i_dst_data[7:1])}
      && o_status_flags[0] == $past(i_dst_data[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");
  property p_asr;
    tk && i_op_code == bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP |=> o_rd_we
      && o_rd_wdata == {$past(i_dst_data[7]), $past(i_dst_data[7:1])};
  endproperty
  a_asr: assert property (p_asr) else $error("arith shift wrong");
  property p_swap;
    tk && i_op_code == bsx_pkg::BSX_NIBBLE_SWAP_OP |=> o_rd_we
      && o_rd_wdata == {$past(i_dst_data[3:0]), $past(i_dst_data[7:4])} && $stable(o_status_flags);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_cset;
    tk && i_op_code == bsx_pkg::BSX_CARRY_SET_OP |=> o_status_flags == ($past(o_status_flags) | 8'h01);
  endproperty
  a_cset: assert property (p_cset) else $error("carry set wrong");
  property p_idis;
    tk && i_op_code == bsx_pkg::BSX_IRQ_DISABLE_OP |=> !o_irq_enable && !o_status_flags[7];
  endproperty
  a_idis: assert property (p_idis) else $error("irq disable wrong");
endmodule
bind bsx_exec_unit bsx_exec_unit_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_dst_data(i_dst_data),
  .i_bit_sel(i_bit_sel), .i_io_addr(i_io_addr), .i_io_rdata(i_io_rdata),
  .i_stack_data(i_stack_data), .i_reg_wr(i_reg_wr), .o_op_ready(o_op_ready),
  .o_rd_we(o_rd_we), .o_rd_wdata(o_rd_wdata), .o_io_we(o_io_we), .o_io_wr_addr(o_io_wr_addr),
  .o_io_wdata(o_io_wdata), .o_status_flags(o_status_flags), .o_irq_enable(o_irq_enable));
`default_nettype wire

// ### sim/tb.sv
// self-checking bench of the bit, shift and flag execution unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_op_valid = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  bsx_pkg::bsx_op_t i_op_code = bsx_pkg::BSX_STACK_POP_OP;
  logic [7:0] i_dst_data = 8'h00;
  logic [7:0] i_src_data = 8'h00;
  logic [2:0] i_bit_sel = 3'h0;
  logic [5:0] i_io_addr = 6'h2B;
  logic [7:0] i_stack_data = 8'hFF;
  logic [7:0] i_io_rdata = 8'hFF;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic o_op_ready, o_rd_we, o_stack_rd, o_io_rd, o_io_we, o_irq_enable;
  logic [5:0] o_io_rd_addr, o_io_wr_addr;
  logic [7:0] o_rd_wdata, o_io_wdata, o_status_flags, o_reg_rdata;
  logic [2:0] seen;
  logic [5:0] addr_seen;
  int n_errors = 0;
  int num_checks = 0;
  always #12.5 i_mclk = ~i_mclk;
  bsx_exec_unit uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid),
    .i_op_code(i_op_code), .i_dst_data(i_dst_data), .i_src_data(i_src_data),
    .i_bit_sel(i_bit_sel), .i_io_addr(i_io_addr), .o_op_ready(o_op_ready), .o_rd_we(o_rd_we),
    .o_rd_wdata(o_rd_wdata), .o_stack_rd(o_stack_rd), .i_stack_data(i_stack_data),
    .o_io_rd(o_io_rd), .o_io_rd_addr(o_io_rd_addr), .i_io_rdata(i_io_rdata),
    .o_io_we(o_io_we), .o_io_wr_addr(o_io_wr_addr), .o_io_wdata(o_io_wdata),
    .o_status_flags(o_status_flags), .o_irq_enable(o_irq_enable), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
  task automatic complete_run;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, e);
  endtask
  // x is the stack or io byte offered in the cycle after the take
  task automatic op(input bsx_pkg::bsx_op_t c, input logic [7:0] d, input logic [7:0] s,
                    input logic [2:0] b, input logic [7:0] x);
    @(posedge i_mclk);
    i_op_valid <= 1'b1;
    i_op_code <= c;
    i_dst_data <= d;
    i_src_data <= s;
    i_bit_sel <= b;
    #1 seen = {o_stack_rd, o_io_rd, o_op_ready};
    addr_seen = o_io_rd_addr;
    @(posedge i_mclk);
    i_op_valid <= 1'b0;
    i_dst_data <= ~d;
    i_stack_data <= x;
    i_io_rdata <= x;
    #1;
  endtask
  // second half of pop and io ops; data lines show the inverse once released
  task automatic finish_long(input logic [7:0] x);
    chk({7'h0, o_op_ready}, 8'h00);
    @(posedge i_mclk);
    i_stack_data <= ~x;
    i_io_rdata <= ~x;
    #1;
  endtask
  task automatic shift_case(input bsx_pkg::bsx_op_t c, input logic [7:0] d, input logic ci,
                            input logic [7:0] r, input logic co);
    reg_wr(bsx_pkg::REG_STATUS, {7'h0, ci});
    op(c, d, 8'h00, 3'h0, 8'h00);
    chk(o_rd_wdata, r);
    chk({7'h0, o_rd_we}, 8'h01);
    chk(o_status_flags, {4'h0, r[7] ^ co, r[7], r == 8'h00, co});
  endtask
  task automatic fop(input bsx_pkg::bsx_op_t c, input logic [7:0] st, input logic [7:0] e);
    reg_wr(bsx_pkg::REG_STATUS, st);
    op(c, 8'h00, 8'h00, 3'h0, 8'h00);
    chk(o_status_flags, e);
    chk({7'h0, o_irq_enable}, {7'h0, e[7]});
  endtask
  task automatic io_case(input bsx_pkg::bsx_op_t c, input logic [7:0] rd, input logic [2:0] b,
                         input logic [5:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_io_addr <= a;
    op(c, 8'h00, 8'h00, b, rd);
    chk({5'h0, seen}, 8'h03);
    chk({2'h0, addr_seen}, {2'h0, a});
    finish_long(rd);
    chk(o_io_wdata, e);
    chk({7'h0, o_io_we}, 8'h01);
    chk({2'h0, o_io_wr_addr}, {2'h0, a});
  endtask
  task automatic sc_reset;
    chk({7'h0, o_op_ready}, 8'h01);
    reg_rd(bsx_pkg::REG_STATUS, 8'h00);
    reg_rd(bsx_pkg::REG_CTRL, 8'h01);
    // read data stands for one cycle only
    @(posedge i_mclk);
    #1 chk(o_reg_rdata, 8'h00);
    reg_wr(bsx_pkg::REG_RESULT, 8'hAA);
    reg_rd(bsx_pkg::REG_RESULT, 8'h00);
    reg_rd(bsx_pkg::REG_OPCOUNT, 8'h00);
    reg_rd(4'hF, 8'h00);
  endtask
  task automatic sc_tbit;
    reg_wr(bsx_pkg::REG_STATUS, 8'h00);
    op(bsx_pkg::BSX_REG_BIT_TO_TRANSFER_FLAG_OP, 8'h00, 8'h10, 3'h4, 8'h00);
    chk(o_status_flags, 8'h40);
    op(bsx_pkg::BSX_TRANSFER_FLAG_TO_REG_BIT_OP, 8'h00, 8'hEF, 3'h7, 8'h00);
    chk(o_rd_wdata, 8'h80);
    chk(o_status_flags, 8'h40);
    op(bsx_pkg::BSX_REG_BIT_TO_TRANSFER_FLAG_OP, 8'hFF, 8'hFE, 3'h0, 8'h00);
    chk(o_status_flags, 8'h00);
    op(bsx_pkg::BSX_TRANSFER_FLAG_TO_REG_BIT_OP, 8'hFF, 8'h00, 3'h0, 8'h00);
    chk(o_rd_wdata, 8'hFE);
  endtask
  task automatic sc_sbit;
    for (int i = 0; i < 8; i++)
    begin
      reg_wr(bsx_pkg::REG_STATUS, 8'h00);
      op(bsx_pkg::BSX_STATUS_BIT_SET_OP, 8'h00, 8'h00, i[2:0], 8'h00);
      chk(o_status_flags, 8'h01 << i);
      reg_wr(bsx_pkg::REG_STATUS, 8'hFF);
      op(bsx_pkg::BSX_STATUS_BIT_CLEAR_OP, 8'h00, 8'h00, i[2:0], 8'h00);
      chk(o_status_flags, ~(8'h01 << i));
    end
  endtask
  task automatic sc_pop;
    reg_wr(bsx_pkg::REG_STATUS, 8'h33);
    op(bsx_pkg::BSX_STACK_POP_OP, 8'h00, 8'h00, 3'h0, 8'hA7);
    chk({5'h0, seen}, 8'h05);
    chk({7'h0, o_rd_we}, 8'h00);
    finish_long(8'hA7);
    chk(o_rd_wdata, 8'hA7);
    chk(o_status_flags, 8'h33);
  endtask
  task automatic sc_gate;
    // an undefined code is taken and counted but changes nothing
    reg_wr(bsx_pkg::REG_STATUS, 8'hA5);
    op(bsx_pkg::bsx_op_t'(5'h1F), 8'h00, 8'h00, 3'h0, 8'h00);
    chk(o_status_flags, 8'hA5);
    chk({7'h0, o_rd_we}, 8'h00);
    reg_wr(bsx_pkg::REG_CTRL, 8'h00);
    reg_wr(bsx_pkg::REG_STATUS, 8'h00);
    op(bsx_pkg::BSX_CARRY_SET_OP, 8'h00, 8'h00, 3'h0, 8'h00);
    chk({5'h0, seen}, 8'h00);
    chk(o_status_flags, 8'h00);
    // 40 ops taken in all; the refused one is not counted
    reg_rd(bsx_pkg::REG_OPCOUNT, 8'h28);
    reg_wr(bsx_pkg::REG_CTRL, 8'h01);
  endtask
  initial
  begin
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    sc_reset;
    shift_case(bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP, 8'h81, 1'b0, 8'h02, 1'b1);
    shift_case(bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP, 8'h80, 1'b0, 8'h00, 1'b1);
    shift_case(bsx_pkg::BSX_SHIFT_RIGHT_LOGICAL_OP, 8'h81, 1'b1, 8'h40, 1'b1);
    shift_case(bsx_pkg::BSX_ROTATE_LEFT_CARRY_OP, 8'h80, 1'b1, 8'h01, 1'b1);
    shift_case(bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP, 8'h02, 1'b1, 8'h81, 1'b0);
    shift_case(bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP, 8'h81, 1'b0, 8'hC0, 1'b1);
    reg_wr(bsx_pkg::REG_STATUS, 8'h5A);
    op(bsx_pkg::BSX_NIBBLE_SWAP_OP, 8'h3C, 8'h00, 3'h0, 8'h00);
    chk(o_rd_wdata, 8'hC3);
    chk(o_status_flags, 8'h5A);
    reg_rd(bsx_pkg::REG_RESULT, 8'hC3);
    sc_tbit;
    sc_sbit;
    fop(bsx_pkg::BSX_CARRY_SET_OP, 8'h00, 8'h01);
    fop(bsx_pkg::BSX_CARRY_CLEAR_OP, 8'hFF, 8'hFE);
    fop(bsx_pkg::BSX_NEGATIVE_SET_OP, 8'h00, 8'h04);
    fop(bsx_pkg::BSX_NEGATIVE_CLEAR_OP, 8'hFF, 8'hFB);
    fop(bsx_pkg::BSX_ZERO_SET_OP, 8'h00, 8'h02);
    fop(bsx_pkg::BSX_ZERO_CLEAR_OP, 8'hFF, 8'hFD);
    fop(bsx_pkg::BSX_IRQ_ENABLE_OP, 8'h00, 8'h80);
    fop(bsx_pkg::BSX_IRQ_DISABLE_OP, 8'hFF, 8'h7F);
    sc_pop;
    io_case(bsx_pkg::BSX_IO_BIT_SET_OP, 8'h50, 3'h1, 6'h2B, 8'h52);
    io_case(bsx_pkg::BSX_IO_BIT_CLEAR_OP, 8'h5A, 3'h3, 6'h15, 8'h52);
    io_case(bsx_pkg::BSX_IO_BIT_CLEAR_OP, 8'hFF, 3'h7, 6'h3F, 8'h7F);
    sc_gate;
    complete_run;
  end
  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
